// ===== rtl/port_pins_irq.sv
// port pin logic with external interrupt and keypad detection behind an apb slave
//
// The APB register port was left to the implementer.
`timescale 1ns/100ps
module port_pins_irq (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // port pads
  input  wire logic [21:0] pad_in,
  output logic      [21:0] pad_out,
  output logic      [21:0] pad_oe,
  output logic      [21:0] pad_pullup,
  output logic      [21:0] input_buf_en,
  // alternate functions, outer ranks above inner
  input  wire logic [21:0] alt_outer_oe,
  input  wire logic [21:0] alt_outer_out,
  input  wire logic [21:0] alt_inner_oe,
  input  wire logic [21:0] alt_inner_out,
  // external interrupt pins and cpu side
  input  wire logic        ext_irq_a_pin,
  input  wire logic        ext_irq_b_pin,
  input  wire logic [1:0]  ext_irq_ack,
  input  wire logic        stop_mode,
  output logic      [1:0]  ext_irq_req,
  output logic             keypad_irq,
  output logic             wake_req
);

  typedef struct packed {
    logic [21:0] pin_s1;
    logic [21:0] pin_s2;
    logic [1:0]  ext_s1;
    logic [1:0]  ext_s2;
    logic [1:0]  ext_prev;
    logic [1:0]  ext_flag;
    logic [1:0]  trig;
    logic [7:0]  kb_en;
    logic        kb_flag;
    logic        kb_cond_prev;
    logic [21:0] latch;
    logic [21:0] mode_first;
    logic [21:0] mode_second;
    logic [21:0] analog_sel;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [21:0] pad_out;
    logic [21:0] pad_oe;
    logic [21:0] pad_pullup;
    logic [21:0] input_en;
    logic [1:0]  ext_req;
    logic        kb_irq;
    logic        wake;
  } state_s;

  state_s cur_ff;
  state_s nxt_state;

  // buffer enable per pin: analog isolates, stop keeps only enabled keypad pins
  function automatic logic [21:0] buf_enable(input logic [21:0] ana,
                                             input logic        stop,
                                             input logic [7:0]  kben);
    logic [21:0] keep;
    keep = '0;
    keep[gpio_pkg::KB_BASE +: gpio_pkg::KB_PINS] = kben;             // [R19]
    buf_enable = ~ana & ({22{~stop}} | keep);                        // [R15] [R18]
  endfunction

  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] off);
    addr_is = (a == off);
  endfunction

  logic        acc_done;
  logic        wr_now;
  logic        mapped;
  logic [21:0] in_en;
  logic [21:0] pin_view;
  logic [1:0]  ext_fall;
  logic        kb_cond;
  logic [31:0] rd_val;

  assign acc_done = psel & penable & cur_ff.pready;
  assign wr_now   = acc_done & pwrite;
  assign in_en    = buf_enable(cur_ff.analog_sel, stop_mode, cur_ff.kb_en);
  assign pin_view = cur_ff.pin_s2 & in_en;
  assign ext_fall = cur_ff.ext_prev & ~cur_ff.ext_s2;                // [R2]
  // a pressed key pulls its pull-up pin low
  assign kb_cond  = |(cur_ff.kb_en
                    & ~cur_ff.pin_s2[gpio_pkg::KB_BASE +: gpio_pkg::KB_PINS]); // [R7] [R8]

  always_comb begin
    mapped = 1'b1;
    rd_val = '0;
    case (paddr)
      gpio_pkg::OFF_PORT_PINS:   rd_val[21:0] = pin_view;            // [R20]
      gpio_pkg::OFF_LATCH:       rd_val[21:0] = cur_ff.latch;        // [R21]
      gpio_pkg::OFF_LATCH_SET:   rd_val[21:0] = cur_ff.latch;
      gpio_pkg::OFF_LATCH_CLR:   rd_val[21:0] = cur_ff.latch;
      gpio_pkg::OFF_MODE_FIRST:  rd_val[21:0] = cur_ff.mode_first;
      gpio_pkg::OFF_MODE_SECOND: rd_val[21:0] = cur_ff.mode_second;
      gpio_pkg::OFF_ANALOG_SEL:  rd_val[21:0] = cur_ff.analog_sel;
      gpio_pkg::OFF_EXT_CTRL:    rd_val[3:0]  = {cur_ff.ext_flag, cur_ff.trig};
      gpio_pkg::OFF_KB_FLAG:     rd_val[0]    = cur_ff.kb_flag;
      gpio_pkg::OFF_KB_ENABLE:   rd_val[7:0]  = cur_ff.kb_en;        // [R11]
      default:                   mapped       = 1'b0;
    endcase
  end

  always_comb begin
    nxt_state = cur_ff;
    // two-stage synchronisers; stage one feeds only stage two
    nxt_state.pin_s1   = pad_in;                                     // [R22]
    nxt_state.pin_s2   = cur_ff.pin_s1;
    nxt_state.ext_s1   = {ext_irq_b_pin, ext_irq_a_pin};             // [R3] [R22]
    nxt_state.ext_s2   = cur_ff.ext_s1;
    nxt_state.ext_prev = cur_ff.ext_s2;

    // apb: one wait state, answer registered
    nxt_state.pready  = psel & penable & ~cur_ff.pready;
    nxt_state.pslverr = 1'b0;
    nxt_state.prdata  = '0;
    if (psel & penable & ~cur_ff.pready) begin
      nxt_state.prdata  = pwrite ? 32'h0000_0000 : rd_val;
      nxt_state.pslverr = ~mapped;
    end

    if (wr_now) begin
      if (addr_is(paddr, gpio_pkg::OFF_PORT_PINS) || addr_is(paddr, gpio_pkg::OFF_LATCH))
        nxt_state.latch = pwdata[21:0];
      if (addr_is(paddr, gpio_pkg::OFF_LATCH_SET))
        nxt_state.latch = cur_ff.latch | pwdata[21:0];               // [R21]
      if (addr_is(paddr, gpio_pkg::OFF_LATCH_CLR))
        nxt_state.latch = cur_ff.latch & ~pwdata[21:0];              // [R21]
      if (addr_is(paddr, gpio_pkg::OFF_MODE_FIRST))
        nxt_state.mode_first = pwdata[21:0];                         // [R12]
      if (addr_is(paddr, gpio_pkg::OFF_MODE_SECOND))
        nxt_state.mode_second = pwdata[21:0];                        // [R12]
      if (addr_is(paddr, gpio_pkg::OFF_ANALOG_SEL))
        nxt_state.analog_sel = pwdata[21:0];
      if (addr_is(paddr, gpio_pkg::OFF_EXT_CTRL))
        nxt_state.trig = pwdata[gpio_pkg::EXT_TRIG_LSB +: 2];
      if (addr_is(paddr, gpio_pkg::OFF_KB_ENABLE))
        nxt_state.kb_en = pwdata[7:0];                               // [R11]
    end

    // external interrupt flags, set beats any clear in the same cycle
    for (int i = 0; i < 2; i++) begin
      if (!cur_ff.trig[i]) begin
        nxt_state.ext_flag[i] = ~cur_ff.ext_s2[i];                   // [R1] [R5]
      end else if (ext_fall[i]) begin
        nxt_state.ext_flag[i] = 1'b1;                                // [R2]
      end else if (ext_irq_ack[i]) begin
        nxt_state.ext_flag[i] = 1'b0;                                // [R4]
      end else if (wr_now && addr_is(paddr, gpio_pkg::OFF_EXT_CTRL)
                   && pwdata[gpio_pkg::EXT_FLAG_LSB + i]) begin
        nxt_state.ext_flag[i] = 1'b0;
      end
    end

    // keypad flag: press sets, release or software write-one clears
    nxt_state.kb_cond_prev = kb_cond;
    if (kb_cond && !cur_ff.kb_cond_prev)
      nxt_state.kb_flag = 1'b1;                                      // [R8]
    else if (!kb_cond)
      nxt_state.kb_flag = 1'b0;                                      // [R9]
    else if (wr_now && addr_is(paddr, gpio_pkg::OFF_KB_FLAG) && pwdata[0])
      nxt_state.kb_flag = 1'b0;

    // pad drive: outer function, then inner, then the four gpio modes
    for (int p = 0; p < gpio_pkg::NUM_PINS; p++) begin
      nxt_state.pad_pullup[p] = 1'b0;
      if (alt_outer_oe[p]) begin
        nxt_state.pad_oe[p]  = 1'b1;                                 // [R17]
        nxt_state.pad_out[p] = alt_outer_out[p];
      end else if (alt_inner_oe[p]) begin
        nxt_state.pad_oe[p]  = 1'b1;                                 // [R17]
        nxt_state.pad_out[p] = alt_inner_out[p];
      end else begin
        // only four modes; there is no weak quasi-bidirectional pull
        case ({cur_ff.mode_first[p], cur_ff.mode_second[p]})         // [R13] [R14]
          2'h0: begin
            nxt_state.pad_oe[p]  = 1'b0;                             // [R16]
            nxt_state.pad_out[p] = 1'b0;
          end
          2'h1: begin
            nxt_state.pad_oe[p]     = 1'b0;
            nxt_state.pad_out[p]    = 1'b0;
            nxt_state.pad_pullup[p] = 1'b1;
          end
          2'h2: begin
            nxt_state.pad_oe[p]  = 1'b1;
            nxt_state.pad_out[p] = cur_ff.latch[p];
          end
          default: begin
            // open drain only ever pulls low
            nxt_state.pad_oe[p]  = ~cur_ff.latch[p];
            nxt_state.pad_out[p] = 1'b0;
          end
        endcase
      end
    end
    nxt_state.input_en = in_en;

    nxt_state.ext_req = nxt_state.ext_flag;
    nxt_state.kb_irq  = nxt_state.kb_flag;
    // wake straight from the condition so a stopped core needs no flag edge
    nxt_state.wake    = (|nxt_state.ext_flag) | kb_cond;             // [R6] [R10]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_ff             <= '0;
      cur_ff.pin_s1      <= 22'h3fffff;
      cur_ff.pin_s2      <= 22'h3fffff;
      cur_ff.ext_s1      <= 2'h3;
      cur_ff.ext_s2      <= 2'h3;
      cur_ff.ext_prev    <= 2'h3;
      cur_ff.trig        <= gpio_pkg::RST_TRIG;
      cur_ff.kb_en       <= gpio_pkg::RST_KB_ENABLE;
      cur_ff.latch       <= gpio_pkg::RST_LATCH;
      cur_ff.mode_first  <= gpio_pkg::RST_MODE;
      cur_ff.mode_second <= gpio_pkg::RST_MODE;
      cur_ff.analog_sel  <= gpio_pkg::RST_ANALOG;
      cur_ff.input_en    <= 22'h3fffff;
    end else begin
      cur_ff <= nxt_state;
    end
  end

  assign prdata       = cur_ff.prdata;
  assign pready       = cur_ff.pready;
  assign pslverr      = cur_ff.pslverr;
  assign pad_out      = cur_ff.pad_out;
  assign pad_oe       = cur_ff.pad_oe;
  assign pad_pullup   = cur_ff.pad_pullup;
  assign input_buf_en = cur_ff.input_en;
  assign ext_irq_req  = cur_ff.ext_req;
  assign keypad_irq   = cur_ff.kb_irq;
  assign wake_req     = cur_ff.wake;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // request output and flag register from the same next value, so they move together
  level_low_a: assert property (!cur_ff.trig[0] && !cur_ff.ext_s2[0]   // [R1]
    |=> cur_ff.ext_flag[0] && ext_irq_req[0])
    else $error("level mode low did not raise request");
  edge_set_a: assert property (cur_ff.trig[0] && ext_fall[0]           // [R2]
    |=> cur_ff.ext_flag[0])
    else $error("falling edge did not set flag");
  edge_hold_a: assert property (cur_ff.trig[1] && cur_ff.ext_flag[1]   // [R4]
    && !ext_fall[1] && !ext_irq_ack[1] && !wr_now |=> cur_ff.ext_flag[1])
    else $error("edge flag lost without acknowledge");
  edge_ack_a: assert property (cur_ff.trig[0] && !ext_fall[0]          // [R4]
    && ext_irq_ack[0] |=> !cur_ff.ext_flag[0])
    else $error("acknowledge did not clear edge flag");
  sync_delay_a: assert property (cur_ff.ext_s2[1] != $past(cur_ff.ext_s2[1])  // [R22]
    |-> cur_ff.ext_s2[1] == $past(cur_ff.ext_s1[1]))
    else $error("synchroniser stage skipped");
  kb_set_a: assert property (kb_cond && !cur_ff.kb_cond_prev           // [R8]
    |=> cur_ff.kb_flag && keypad_irq)
    else $error("key press did not set keypad flag");
  kb_release_a: assert property (!kb_cond |=> !cur_ff.kb_flag)         // [R9]
    else $error("keypad flag stayed after release");
  wake_key_a: assert property (kb_cond |=> wake_req)                   // [R10]
    else $error("enabled key did not wake");
  kb_enable_a: assert property (wr_now && paddr == gpio_pkg::OFF_KB_ENABLE  // [R11]
    |=> cur_ff.kb_en == $past(pwdata[7:0]))
    else $error("keypad enable write lost");
  push_pull_a: assert property (cur_ff.mode_first[0] && !cur_ff.mode_second[0]  // [R13]
    && !alt_outer_oe[0] && !alt_inner_oe[0]
    |=> pad_oe[0] && pad_out[0] == $past(cur_ff.latch[0]))
    else $error("push-pull pin not driving latch");
  input_only_a: assert property (!cur_ff.mode_first[3]                 // [R16]
    && !alt_outer_oe[3] && !alt_inner_oe[3] |=> !pad_oe[3])
    else $error("input mode pin is driving");
  outer_wins_a: assert property (alt_outer_oe[5] && alt_inner_oe[5]    // [R17]
    |=> pad_oe[5] && pad_out[5] == $past(alt_outer_out[5]))
    else $error("inner function beat outer one");
  stop_buf_a: assert property (stop_mode && !cur_ff.kb_en[2]           // [R18]
    |=> !input_buf_en[10])
    else $error("buffer left on in stop mode");
  analog_read_a: assert property (cur_ff.analog_sel[1]                 // [R15]
    |-> !pin_view[1])
    else $error("analog pin visible to digital read");
  latch_set_a: assert property (wr_now && paddr == gpio_pkg::OFF_LATCH_SET  // [R21]
    |=> cur_ff.latch == ($past(cur_ff.latch) | $past(pwdata[21:0])))
    else $error("bit set did not merge with latch");

  // second interrupt input, the mirror cases of the level and edge logic, synchronisers, wake and keypad enable
  level_b_low_a: assert property (!cur_ff.trig[1] && !cur_ff.ext_s2[1] // [R1]
    |=> cur_ff.ext_flag[1])
    else $error("level mode low did not raise request b");
  level_high_a: assert property (!cur_ff.trig[0] && cur_ff.ext_s2[0]   // [R1]
    |=> !cur_ff.ext_flag[0])
    else $error("level request stayed after pin released");
  ack_level_a: assert property (!cur_ff.trig[0] && !cur_ff.ext_s2[0]   // [R1]
    && ext_irq_ack[0] |=> cur_ff.ext_flag[0])
    else $error("acknowledge cleared a held level request");
  edge_set_b_a: assert property (cur_ff.trig[1] && ext_fall[1]         // [R2]
    |=> cur_ff.ext_flag[1])
    else $error("falling edge did not set flag b");
  edge_ack_b_a: assert property (cur_ff.trig[1] && !ext_fall[1]        // [R4]
    && ext_irq_ack[1] |=> !cur_ff.ext_flag[1])
    else $error("acknowledge did not clear edge flag b");
  sync_a_a: assert property (cur_ff.ext_s2[0] != $past(cur_ff.ext_s2[0])  // [R22]
    |-> cur_ff.ext_s2[0] == $past(cur_ff.ext_s1[0]))
    else $error("synchroniser stage skipped on input a");
  pin_sync_a: assert property (cur_ff.pin_s2 == $past(cur_ff.pin_s1))  // [R22]
    else $error("pad synchroniser stage skipped");
  wake_ext_a: assert property (|cur_ff.ext_flag |-> wake_req)          // [R6]
    else $error("external request did not wake");
  kb_disabled_a: assert property (cur_ff.kb_en == 8'h00                // [R8]
    |=> !cur_ff.kb_flag)
    else $error("keypad flag set with no line enabled");

  // pad drive and input buffers
  open_drain_a: assert property (cur_ff.mode_first[0] && cur_ff.mode_second[0]  // [R13]
    && !alt_outer_oe[0] && !alt_inner_oe[0]
    |=> !pad_out[0] && pad_oe[0] == !$past(cur_ff.latch[0]))
    else $error("open-drain pin drove high");
  pullup_a: assert property (!cur_ff.mode_first[1] && cur_ff.mode_second[1]  // [R13]
    && !alt_outer_oe[1] && !alt_inner_oe[1] |=> pad_pullup[1] && !pad_oe[1])
    else $error("pull-up input mode wrong");
  inner_used_a: assert property (!alt_outer_oe[5] && alt_inner_oe[5]   // [R17]
    |=> pad_oe[5] && pad_out[5] == $past(alt_inner_out[5]))
    else $error("inner function not given the free pin");
  stop_kb_keep_a: assert property (stop_mode && cur_ff.kb_en[0]        // [R19]
    && !cur_ff.analog_sel[8] |=> input_buf_en[8])
    else $error("keypad buffer turned off in stop mode");
  run_buf_a: assert property (!stop_mode && !cur_ff.analog_sel[4]      // [R18]
    |=> input_buf_en[4])
    else $error("buffer off outside stop mode");

  // register bus side
  latch_clr_a: assert property (wr_now && paddr == gpio_pkg::OFF_LATCH_CLR  // [R21]
    |=> cur_ff.latch == ($past(cur_ff.latch) & ~$past(pwdata[21:0])))
    else $error("bit clear did not merge with latch");
  pins_read_a: assert property (psel && penable && !cur_ff.pready && !pwrite  // [R20]
    && paddr == gpio_pkg::OFF_PORT_PINS |=> prdata[21:0] == $past(pin_view))
    else $error("port read did not return pins");
  kb_read_a: assert property (psel && penable && !cur_ff.pready && !pwrite  // [R11]
    && paddr == gpio_pkg::OFF_KB_ENABLE |=> prdata[7:0] == $past(cur_ff.kb_en))
    else $error("keypad enable read wrong");
  apb_answer_a: assert property (psel && penable && !cur_ff.pready     // [R12]
    |=> pready ##1 !pready)
    else $error("bus answer not a single pulse");
  unmapped_err_a: assert property (psel && penable && !cur_ff.pready   // [R12]
    && !mapped |=> pslverr)
    else $error("unmapped access not flagged");

  edge_seen_c: cover property (cur_ff.trig[0] && ext_fall[0] ##1 ext_irq_ack[0]);
  key_cycle_c: cover property (kb_cond ##1 cur_ff.kb_flag ##[1:20] !cur_ff.kb_flag);
  stop_wake_c: cover property (stop_mode && kb_cond ##1 wake_req);
  open_drain_c: cover property (cur_ff.mode_first[0] && cur_ff.mode_second[0]
    && !cur_ff.latch[0] ##1 pad_oe[0]);

endmodule

// ===== rtl/gpio_pkg.sv
// package with register map, field positions and reset values of the port block
// What this block does
// (R1) trigger type 0: a low level on an external interrupt pin raises its request
// (R2) trigger type 1: high sample then low sample sets the request flag
// (R3) each interrupt pin sampled every clock; source holds each level two clocks
// (R4) edge mode: request flag clears when the cpu enters the service routine
// (R5) level mode: source must release its low before the routine ends
// (R6) either external interrupt request can wake the device from power-down
// (R7) eight keypad inputs, individually enabled, on port 1 pins 0 to 7
// (R8) keypad flag sets on an interrupt condition at an enabled port 1 pin
// (R9) keypad flag clears by hardware once the pressed key is released
// (R10) any enabled keypad input wakes the device from idle, stop and sleep
// (R11) keypad enable register is 8 bits, read/write, resets to zero
// (R12) three ports, 22 pins, each with output latch and two mode bits per pin
// (R13) mode bits 00 input, 01 pull-up input, 10 push-pull, 11 open-drain
// (R14) no quasi-bidirectional behaviour, only the four modes exist
// (R15) a pin selected as analog has its digital input path disabled
// (R16) analog pins lose output drive by being placed in input-only mode
// (R17) shared pin goes to the outer function first, blocking inner ones
// (R18) in stop mode all input buffers off except interrupt, reset and crystal pins
// (R19) enabled keypad pins keep their input buffers on during stop mode
// (R20) an ordinary port read returns the pin state, not the latch
// (R21) read-modify-write and bit set/clear use the latch, then write the whole port
// (R22) external interrupt and keypad inputs pass a two-stage synchroniser first
package gpio_pkg;
  localparam int          NUM_PINS      = 22;
  localparam int          KB_PINS       = 8;
  localparam int          KB_BASE       = 8;  // port 1 starts at pin 8
  localparam int          ADDR_W        = 12;
  // register byte offsets
  localparam logic [11:0] OFF_PORT_PINS = 12'h000;
  localparam logic [11:0] OFF_LATCH     = 12'h004;
  localparam logic [11:0] OFF_LATCH_SET = 12'h008;
  localparam logic [11:0] OFF_LATCH_CLR = 12'h00c;
  localparam logic [11:0] OFF_MODE_FIRST  = 12'h010;
  localparam logic [11:0] OFF_MODE_SECOND = 12'h014;
  localparam logic [11:0] OFF_ANALOG_SEL  = 12'h018;
  localparam logic [11:0] OFF_EXT_CTRL  = 12'h01c;
  localparam logic [11:0] OFF_KB_FLAG   = 12'h020;
  localparam logic [11:0] OFF_KB_ENABLE = 12'h0bc;
  // ext control fields: trigger types in bits 1:0, request flags in bits 3:2
  localparam int          EXT_TRIG_LSB  = 0;
  localparam int          EXT_FLAG_LSB  = 2;
  // reset values
  localparam logic [21:0] RST_LATCH     = 22'h3fffff;
  localparam logic [21:0] RST_MODE      = 22'h000000;
  localparam logic [21:0] RST_ANALOG    = 22'h000000;
  localparam logic [7:0]  RST_KB_ENABLE = 8'h00;
  localparam logic [1:0]  RST_TRIG      = 2'h0;
endpackage

// ===== verif/pin_partner.sv
// far-side model: pin loads, keypad switches to ground and interrupt sources
`timescale 1ns/100ps
module pin_partner (
  // clock
  input  wire logic        pclk,
  // pads from the port
  input  wire logic [21:0] pad_out,
  input  wire logic [21:0] pad_oe,
  input  wire logic [21:0] pad_pullup,
  // stimulus from the bench
  input  wire logic [7:0]  key_down,
  input  wire logic        src_a_lvl,
  input  wire logic        src_b_lvl,
  // levels seen by the port
  output logic      [21:0] pad_in,
  output logic             ext_irq_a_pin,
  output logic             ext_irq_b_pin
);
  logic [21:0] float_pat;
  logic [21:0] keys;

  initial float_pat = 22'h155555;
  // an undriven pin without pull-up wanders, so no check may lean on it
  always @(posedge pclk) float_pat <= ~float_pat;
  // a pressed key shorts its port 1 line to ground
  assign keys = {6'h00, key_down, 8'h00};
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ~keys & (pad_pullup | float_pat));
  // interrupt sources drive both levels themselves
  assign ext_irq_a_pin = src_a_lvl;
  assign ext_irq_b_pin = src_b_lvl;
endmodule

// ===== verif/tb_top.sv
// testbench for the port block: apb register tasks, pin, keypad and interrupt sequences
`timescale 1ns/100ps
module tb_top;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [21:0] pad_in;
  logic [21:0] pad_out;
  logic [21:0] pad_oe;
  logic [21:0] pad_pullup;
  logic [21:0] input_buf_en;
  logic [21:0] alt_outer_oe;
  logic [21:0] alt_outer_out;
  logic [21:0] alt_inner_oe;
  logic [21:0] alt_inner_out;
  logic        ext_irq_a_pin;
  logic        ext_irq_b_pin;
  logic [1:0]  ext_irq_ack;
  logic        stop_mode;
  logic [1:0]  ext_irq_req;
  logic        keypad_irq;
  logic        wake_req;
  logic [7:0]  key_down;
  logic        src_a_lvl;
  logic        src_b_lvl;
  logic [31:0] rd;
  logic        err;
  int          n_mismatch;
  int          checks_done;
  int          cycles;

  port_pins_irq u_port_pins_irq (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe(pad_oe), .pad_pullup(pad_pullup), .input_buf_en(input_buf_en),
    .alt_outer_oe(alt_outer_oe), .alt_outer_out(alt_outer_out),
    .alt_inner_oe(alt_inner_oe), .alt_inner_out(alt_inner_out),
    .ext_irq_a_pin(ext_irq_a_pin), .ext_irq_b_pin(ext_irq_b_pin),
    .ext_irq_ack(ext_irq_ack), .stop_mode(stop_mode), .ext_irq_req(ext_irq_req),
    .keypad_irq(keypad_irq), .wake_req(wake_req));
  pin_partner u_pin_partner (.pclk(pclk), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup(pad_pullup), .key_down(key_down), .src_a_lvl(src_a_lvl),
    .src_b_lvl(src_b_lvl), .pad_in(pad_in), .ext_irq_a_pin(ext_irq_a_pin),
    .ext_irq_b_pin(ext_irq_b_pin));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic summarize;
    if (n_mismatch == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // the request stays put until pready is sampled high; no wait count is assumed
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      summarize();
    end
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, ext_irq_ack, stop_mode, key_down} = '0;
    {alt_outer_oe, alt_outer_out, alt_inner_oe, alt_inner_out} = '0;
    {src_a_lvl, src_b_lvl, presetn, n_mismatch, checks_done, cycles} = '0;
    src_a_lvl = 1'b1;
    src_b_lvl = 1'b1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, gpio_pkg::OFF_KB_ENABLE, 32'h0);
    chk(rd, 32'h00000000);
    apb(1'b0, gpio_pkg::OFF_LATCH, 32'h0);
    chk(rd, 32'h003fffff);
    apb(1'b0, 12'h040, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, gpio_pkg::OFF_KB_ENABLE, 32'h000000a5);
    apb(1'b0, gpio_pkg::OFF_KB_ENABLE, 32'h0);
    chk(rd, 32'h000000a5);
    // pins 0..3 take the four modes; port 1 gets pull-ups so idle keys read high
    apb(1'b1, gpio_pkg::OFF_MODE_FIRST, 32'h0000000c);
    apb(1'b1, gpio_pkg::OFF_MODE_SECOND, 32'h0000ff0a);
    idle(2);
    chk({28'h0, pad_oe[3:0]}, 32'h4);
    chk({28'h0, pad_pullup[3:0]}, 32'h2);
    chk({31'h0, pad_out[2]}, 32'h1);
    apb(1'b1, gpio_pkg::OFF_LATCH_CLR, 32'h0000000c);
    apb(1'b0, gpio_pkg::OFF_LATCH_SET, 32'h0);
    chk(rd, 32'h003ffff3);
    idle(2);
    chk({28'h0, pad_oe[3:0]}, 32'hc);
    alt_outer_oe <= 22'h000004;
    alt_outer_out <= 22'h000004;
    alt_inner_oe <= 22'h000004;
    idle(4);
    chk({31'h0, pad_out[2]}, 32'h1);
    apb(1'b0, gpio_pkg::OFF_PORT_PINS, 32'h0);
    chk(rd & 32'h6, 32'h6);
    alt_outer_oe <= 22'h000000;
    idle(2);
    chk({31'h0, pad_out[2]}, 32'h0);
    apb(1'b1, gpio_pkg::OFF_ANALOG_SEL, 32'h00000002);
    idle(4);
    chk({31'h0, input_buf_en[1]}, 32'h0);
    apb(1'b0, gpio_pkg::OFF_PORT_PINS, 32'h0);
    chk(rd & 32'h6, 32'h0);
    // level mode on source a, held low well beyond two clocks
    src_a_lvl <= 1'b0;
    idle(2);
    chk({31'h0, ext_irq_req[0]}, 32'h0);
    for (int k = 0; k < 4 && ext_irq_req[0] !== 1'b1; k++) idle(1);
    chk({31'h0, ext_irq_req[0]}, 32'h1);
    chk({31'h0, wake_req}, 32'h1);
    ext_irq_ack <= 2'b01;
    idle(1);
    ext_irq_ack <= 2'b00;
    idle(3);
    chk({31'h0, ext_irq_req[0]}, 32'h1);
    src_a_lvl <= 1'b1;
    idle(6);
    chk({30'h0, ext_irq_req}, 32'h0);
    // edge mode on source b: flag holds while low, cleared by acknowledge
    apb(1'b1, gpio_pkg::OFF_EXT_CTRL, 32'h00000002);
    idle(2);
    src_b_lvl <= 1'b0;
    idle(6);
    chk({31'h0, ext_irq_req[1]}, 32'h1);
    chk({31'h0, wake_req}, 32'h1);
    ext_irq_ack <= 2'b10;
    idle(1);
    ext_irq_ack <= 2'b00;
    idle(3);
    chk({31'h0, ext_irq_req[1]}, 32'h0);
    src_b_lvl <= 1'b1;
    // keypad: only the enabled line may set the flag
    apb(1'b1, gpio_pkg::OFF_KB_ENABLE, 32'h00000001);
    key_down <= 8'h02;
    idle(8);
    chk({31'h0, keypad_irq}, 32'h0);
    key_down <= 8'h03;
    idle(6);
    chk({31'h0, keypad_irq}, 32'h1);
    chk({31'h0, wake_req}, 32'h1);
    apb(1'b0, gpio_pkg::OFF_KB_FLAG, 32'h0);
    chk(rd & 32'h1, 32'h1);
    key_down <= 8'h00;
    idle(6);
    chk({31'h0, keypad_irq}, 32'h0);
    stop_mode <= 1'b1;
    idle(3);
    chk({10'h0, input_buf_en}, 32'h00000100);
    summarize();
  end
endmodule
